// ==== input_terminal_function_router.sv ====
// input terminal function router: five assignable terminals to drive commands
// assumes a single-master AHB-Lite bus on hclk and terminal pins asynchronous to it
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module input_terminal_function_router
	import term_router_pkg::*;
#(
	parameter int SLOW_CYCLES = SLOW_SAMPLE_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [NUM_TERM-1:0] terminal_in,
	input wire logic drive_running,
	output drive_cmd_t drive_cmd
);

	localparam logic [SLOW_CNT_W-1:0] SLOW_LAST = SLOW_CNT_W'(SLOW_CYCLES - 1);

	// whole module state
	typedef struct packed {
		logic [NUM_TERM-1:0] sync1;
		logic [NUM_TERM-1:0] sync2;
		logic [NUM_TERM-1:0] slow_term;
		logic [SLOW_CNT_W-1:0] slow_cnt;
		logic [NUM_TERM-1:0][CODE_W-1:0] func_sel;
		logic [7:0] remote_sel;
		logic [2:0] shutoff_sel;
		logic [3:0] op_mode;
		logic [CODE_W-1:0] ext_access;
		logic comm_shutoff;
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_addr;
		logic rd_wait;
		ahb_rsp_t rsp;
		drive_cmd_t cmd;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	logic addr_take;
	logic remote_mode;
	logic shut_term;
	logic shut_active;
	logic any_multi;
	logic vf_in;
	logic [31:0] rd_mux;
	drive_cmd_t c;

	// OR of a terminal vector over every terminal carrying the given code
	function automatic logic func_or(input logic [NUM_TERM-1:0][CODE_W-1:0] sel,
			input logic [NUM_TERM-1:0] term, input logic [CODE_W-1:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_TERM; i++) begin
			r = r | ((sel[i] == code) & term[i]);
		end
		return r;
	endfunction

	// true when any terminal carries the given code
	function automatic logic func_used(input logic [NUM_TERM-1:0][CODE_W-1:0] sel,
			input logic [CODE_W-1:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_TERM; i++) begin
			r = r | (sel[i] == code);
		end
		return r;
	endfunction

	// register read mux, based on the held data-phase address
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (s_r.dp_addr <= OFS_FUNC_SEL4 && s_r.dp_addr[1:0] == 2'h0) begin
			rd_mux = {18'h0, s_r.func_sel[s_r.dp_addr[4:2]]};
		end else begin
			case (s_r.dp_addr)
				OFS_REMOTE_SEL: rd_mux = {24'h0, s_r.remote_sel};
				OFS_SHUTOFF_SEL: rd_mux = {29'h0, s_r.shutoff_sel};
				OFS_OPMODE: rd_mux = {28'h0, s_r.op_mode};
				OFS_EXT_ACCESS: rd_mux = {18'h0, s_r.ext_access};
				OFS_COMM_CTRL: rd_mux = {31'h0, s_r.comm_shutoff};
				OFS_STATUS: rd_mux = s_r.cmd;
				OFS_TERM_RAW: rd_mux = {27'h0, s_r.sync2};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// shutoff function and its contact logic
	always_comb begin
		// fast path reads the synchroniser output directly
		shut_term = func_or(s_r.func_sel, s_r.sync2, CODE_SHUTOFF);
		case (s_r.shutoff_sel)
			SHUTOFF_NO: shut_active = shut_term | s_r.comm_shutoff;
			SHUTOFF_NC: shut_active = ~(shut_term & s_r.comm_shutoff);
			SHUTOFF_MIXED: shut_active = ~(shut_term & ~s_r.comm_shutoff);
			default: shut_active = 1'b1;
		endcase
	end

	// decode of every assignable function
	always_comb begin
		c = '0;
		remote_mode = (s_r.remote_sel != 8'h00);
		// codes 0-2 keep their terminals, only their meaning switches
		c.speed_low_input = ~remote_mode & func_or(s_r.func_sel, s_r.slow_term, CODE_LOW);
		c.speed_mid_input = ~remote_mode & func_or(s_r.func_sel, s_r.slow_term, CODE_MID);
		c.speed_high_input = ~remote_mode & func_or(s_r.func_sel, s_r.slow_term, CODE_HIGH);
		c.remote_clear = remote_mode & func_or(s_r.func_sel, s_r.slow_term, CODE_LOW);
		c.remote_decel = remote_mode & func_or(s_r.func_sel, s_r.slow_term, CODE_MID);
		c.remote_accel = remote_mode & func_or(s_r.func_sel, s_r.slow_term, CODE_HIGH);
		c.extended_speed_select = func_or(s_r.func_sel, s_r.slow_term, CODE_EXT_SPEED);
		c.jog_select = func_or(s_r.func_sel, s_r.slow_term, CODE_JOG);
		c.pid_valid = func_or(s_r.func_sel, s_r.slow_term, CODE_PID);
		any_multi = c.speed_low_input | c.speed_mid_input | c.speed_high_input
			| c.extended_speed_select;
		// speed command source by priority
		if (c.jog_select) begin
			c.speed_source = SRC_JOG;
		end else if (any_multi) begin
			c.speed_source = SRC_MULTI;
		end else if (c.pid_valid) begin
			c.speed_source = SRC_PID;
		end else begin
			c.speed_source = SRC_NONE;
		end
		// control type only changes while stopped
		vf_in = func_or(s_r.func_sel, s_r.slow_term, CODE_VF);
		c.vf_switchover = drive_running ? s_r.cmd.vf_switchover : vf_in;
		c.second_function_select = func_or(s_r.func_sel, s_r.slow_term, CODE_SECOND)
			| vf_in;
		c.current_input_select = func_or(s_r.func_sel, s_r.slow_term, CODE_CUR_IN);
		c.terminal2_voltage_valid = ~c.current_input_select;
		c.ext_thermal_relay = func_or(s_r.func_sel, ~s_r.slow_term, CODE_THERMAL);
		// converter enable falls back to the shutoff input
		if (func_used(s_r.func_sel, CODE_CONV_EN)) begin
			c.converter_operation_enable = func_or(s_r.func_sel, s_r.sync2, CODE_CONV_EN);
		end else begin
			c.converter_operation_enable = ~shut_active;
		end
		// panel interlock falls back to shutoff in mode 7
		if (s_r.op_mode == OPMODE_INTERLOCK && !func_used(s_r.func_sel, CODE_INTERLOCK)) begin
			c.panel_op_interlock = shut_active;
		end else begin
			c.panel_op_interlock = func_or(s_r.func_sel, s_r.slow_term, CODE_INTERLOCK);
		end
		c.panel_external_switch = func_or(s_r.func_sel, s_r.slow_term, CODE_PANEL_EXT);
		c.start_self_hold = func_or(s_r.func_sel, s_r.slow_term, CODE_SELF_HOLD);
		c.traverse_select = func_or(s_r.func_sel, s_r.slow_term, CODE_TRAVERSE);
		// run commands only on their own terminal
		c.forward_run_cmd = (s_r.func_sel[FWD_TERM] == CODE_FWD) & s_r.slow_term[FWD_TERM];
		c.reverse_run_cmd = (s_r.func_sel[REV_TERM] == CODE_REV) & s_r.slow_term[REV_TERM];
		c.drive_reset_input = func_or(s_r.func_sel, s_r.slow_term, CODE_RESET);
		c.panel_net_switch = func_or(s_r.func_sel, s_r.slow_term, CODE_PANEL_NET);
		c.external_net_switch = func_or(s_r.func_sel, s_r.slow_term, CODE_EXT_NET);
		c.command_source_switch = func_or(s_r.func_sel, s_r.slow_term, CODE_CMD_SRC);
		// shutoff effects on the drive
		c.output_shutoff = shut_active;
		c.output_cut = shut_active;
		c.start_allowed = ~shut_active;
		c.coast_stop = drive_running & shut_active;
		c.decel_stop = drive_running & ~shut_active
			& ~(c.forward_run_cmd | c.reverse_run_cmd);
	end

	assign addr_take = hsel & hready & htrans[1];

	// next state: synchronisers, sampling tick, bus slave, command register
	always_comb begin
		s_nxt = s_r;
		// two-flop synchronisers on every terminal
		s_nxt.sync1 = terminal_in;
		s_nxt.sync2 = s_r.sync1;
		// slow functions sampled every tick, well inside their response time
		if (s_r.slow_cnt == SLOW_LAST) begin
			s_nxt.slow_cnt = '0;
			s_nxt.slow_term = s_r.sync2;
		end else begin
			s_nxt.slow_cnt = s_r.slow_cnt + 1'b1;
		end
		s_nxt.cmd = c;
		// write completes in its data phase
		if (s_r.dp_valid && s_r.dp_write) begin
			if (s_r.dp_addr <= OFS_FUNC_SEL4 && s_r.dp_addr[1:0] == 2'h0) begin
				s_nxt.func_sel[s_r.dp_addr[4:2]] = hwdata[CODE_W-1:0];
			end else begin
				case (s_r.dp_addr)
					OFS_REMOTE_SEL: s_nxt.remote_sel = hwdata[7:0];
					OFS_SHUTOFF_SEL: begin
						// locked unless full parameter access, and only legal values
						if (s_r.ext_access == '0 && (hwdata[2:0] == SHUTOFF_NO
								|| hwdata[2:0] == SHUTOFF_NC
								|| hwdata[2:0] == SHUTOFF_MIXED)
								&& hwdata[31:3] == '0) begin
							s_nxt.shutoff_sel = hwdata[2:0];
						end
					end
					OFS_OPMODE: s_nxt.op_mode = hwdata[3:0];
					OFS_EXT_ACCESS: s_nxt.ext_access = hwdata[CODE_W-1:0];
					OFS_COMM_CTRL: s_nxt.comm_shutoff = hwdata[0];
					default: s_nxt.comm_shutoff = s_r.comm_shutoff;
				endcase
			end
		end
		// reads take one wait cycle so writes just before are seen
		s_nxt.rsp.hresp = 1'b0;
		s_nxt.rsp.hreadyout = 1'b1;
		s_nxt.rd_wait = 1'b0;
		if (s_r.rd_wait) begin
			s_nxt.rsp.hrdata = rd_mux;
			s_nxt.dp_valid = 1'b0;
		end else if (addr_take) begin
			s_nxt.dp_valid = 1'b1;
			s_nxt.dp_write = hwrite;
			s_nxt.dp_addr = haddr[7:0];
			if (!hwrite) begin
				s_nxt.rd_wait = 1'b1;
				s_nxt.rsp.hreadyout = 1'b0;
			end
		end else begin
			s_nxt.dp_valid = 1'b0;
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.func_sel[0] <= RST_SEL0;
			s_r.func_sel[1] <= RST_SEL1;
			s_r.func_sel[2] <= RST_SEL2;
			s_r.func_sel[3] <= RST_SEL3;
			s_r.func_sel[4] <= RST_SEL4;
			s_r.shutoff_sel <= SHUTOFF_NO;
			s_r.rsp.hreadyout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign hrdata = s_r.rsp.hrdata;
	assign hreadyout = s_r.rsp.hreadyout;
	assign hresp = s_r.rsp.hresp;
	assign drive_cmd = s_r.cmd;

endmodule

// ==== input_terminal_function_router_tb.sv ====
// testbench for the input terminal router: bus, shutoff logic and function decode
// assumes the contact model on the pins and a shortened slow sampling period
`timescale 1ns/1ns
module input_terminal_function_router_tb;
	import term_router_pkg::*;
	localparam int SLOW = 8;
	localparam int WAIT = SLOW + 6;
	logic hclk, hresetn, hsel, hwrite, drive_running, hreadyout, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [4:0] closed, terminal_in;
	wire hready;
	drive_cmd_t drive_cmd;
	int failures, comparisons;

	assign hready = hreadyout;
	// block under test and the contacts in front of it
	input_terminal_function_router #(.SLOW_CYCLES(SLOW)) i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.terminal_in(terminal_in), .drive_running(drive_running), .drive_cmd(drive_cmd));
	term_contacts i_sw (.closed(closed), .terminal_in(terminal_in));

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h got %h", n, e, g);
		end
	endtask

	// one single transfer: address phase, then data phase; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic sel(input int t, input logic [13:0] c);
		bus(1'b1, 8'(t * 4), {18'h0, c});
	endtask

	task automatic wt();
		repeat (WAIT) @(posedge hclk);
	endtask

	task automatic t_reset();
		logic [13:0] rst [5];
		rst = '{RST_SEL0, RST_SEL1, RST_SEL2, RST_SEL3, RST_SEL4};
		chk("start_allowed", 1, drive_cmd.start_allowed);
		chk("conv_enable", 1, drive_cmd.converter_operation_enable);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0);
			chk("func_sel", {18'h0, rst[i]}, q);
		end
		bus(1'b0, OFS_SHUTOFF_SEL, 32'h0);
		chk("shutoff_sel", 0, q);
		bus(1'b1, 8'h40, 32'h5A);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped", 0, q);
	endtask

	task automatic t_shutoff();
		drive_running <= 1'b1;
		sel(2, CODE_SHUTOFF);
		closed[2] <= 1'b1;
		repeat (5) @(posedge hclk);
		chk("shutoff", 1, drive_cmd.output_shutoff);
		chk("output_cut", 1, drive_cmd.output_cut);
		chk("start_allowed", 0, drive_cmd.start_allowed);
		chk("coast_stop", 1, drive_cmd.coast_stop);
		chk("conv_enable", 0, drive_cmd.converter_operation_enable);
		bus(1'b1, OFS_OPMODE, 32'h7);
		repeat (3) @(posedge hclk);
		chk("interlock", 1, drive_cmd.panel_op_interlock);
		closed[2] <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("decel_stop", 1, drive_cmd.decel_stop);
		closed[0] <= 1'b1;
		wt();
		chk("forward_run", 1, drive_cmd.forward_run_cmd);
		chk("no_decel_run", 0, drive_cmd.decel_stop);
		closed[0] <= 1'b0;
	endtask

	// every logic selection against every terminal and communication input pair
	task automatic t_logic();
		logic [2:0] s;
		logic t, m, e;
		for (int i = 0; i < 3; i++) begin
			s = 3'(i * 2);
			bus(1'b1, OFS_SHUTOFF_SEL, {29'h0, s});
			for (int c = 0; c < 4; c++) begin
				t = c[1];
				m = c[0];
				bus(1'b1, OFS_COMM_CTRL, {31'h0, m});
				closed[2] <= t;
				repeat (5) @(posedge hclk);
				e = (s == SHUTOFF_NO) ? (t | m) : (s == SHUTOFF_NC) ? !(t & m) : !(t & !m);
				chk("shutoff_logic", e, drive_cmd.output_shutoff);
			end
		end
		bus(1'b1, OFS_SHUTOFF_SEL, 32'h0);
		bus(1'b1, OFS_COMM_CTRL, 32'h0);
		closed[2] <= 1'b0;
	endtask

	task automatic t_lock();
		bus(1'b1, OFS_EXT_ACCESS, 32'h1);
		bus(1'b1, OFS_SHUTOFF_SEL, 32'h2);
		bus(1'b0, OFS_SHUTOFF_SEL, 32'h0);
		chk("locked_sel", 0, q);
		bus(1'b1, OFS_EXT_ACCESS, 32'h0);
		bus(1'b1, OFS_SHUTOFF_SEL, 32'h2);
		bus(1'b0, OFS_SHUTOFF_SEL, 32'h0);
		chk("open_sel", 2, q);
		bus(1'b1, OFS_SHUTOFF_SEL, 32'h0);
	endtask

	task automatic t_speed();
		sel(3, CODE_LOW);
		sel(4, CODE_LOW);
		sel(2, CODE_JOG);
		closed[4] <= 1'b1;
		wt();
		chk("speed_low", 1, drive_cmd.speed_low_input);
		chk("src_multi", SRC_MULTI, drive_cmd.speed_source);
		closed[2] <= 1'b1;
		wt();
		chk("src_jog", SRC_JOG, drive_cmd.speed_source);
		sel(2, CODE_EXT_SPEED);
		wt();
		chk("ext_speed", 1, drive_cmd.extended_speed_select);
		sel(0, CODE_PID);
		closed[0] <= 1'b1;
		wt();
		chk("src_multi_pid", SRC_MULTI, drive_cmd.speed_source);
		closed[4] <= 1'b0;
		closed[2] <= 1'b0;
		wt();
		chk("src_pid", SRC_PID, drive_cmd.speed_source);
		bus(1'b1, OFS_REMOTE_SEL, 32'h1);
		closed[3] <= 1'b1;
		wt();
		chk("remote_clear", 1, drive_cmd.remote_clear);
		chk("speed_low_off", 0, drive_cmd.speed_low_input);
		bus(1'b1, OFS_REMOTE_SEL, 32'h0);
		closed[3] <= 1'b0;
	endtask

	task automatic t_misc();
		sel(3, CODE_THERMAL);
		wt();
		chk("thermal_open", 1, drive_cmd.ext_thermal_relay);
		closed[3] <= 1'b1;
		wt();
		chk("thermal_closed", 0, drive_cmd.ext_thermal_relay);
		sel(3, CODE_INTERLOCK);
		wt();
		chk("interlock_term", 1, drive_cmd.panel_op_interlock);
		sel(1, CODE_CUR_IN);
		closed[1] <= 1'b1;
		wt();
		chk("volt_valid", 0, drive_cmd.terminal2_voltage_valid);
		sel(1, CODE_CONV_EN);
		closed[1] <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("conv_terminal", 0, drive_cmd.converter_operation_enable);
		sel(0, CODE_NONE);
		wt();
		chk("no_function", 0, drive_cmd.pid_valid);
		sel(2, CODE_CMD_SRC);
		closed[2] <= 1'b1;
		wt();
		chk("cmd_source", 1, drive_cmd.command_source_switch);
		drive_running <= 1'b0;
		sel(4, CODE_VF);
		closed[4] <= 1'b1;
		wt();
		chk("second_func", 1, drive_cmd.second_function_select);
		chk("vf_stopped", 1, drive_cmd.vf_switchover);
		drive_running <= 1'b1;
		closed[4] <= 1'b0;
		wt();
		chk("vf_frozen", 1, drive_cmd.vf_switchover);
		chk("second_off", 0, drive_cmd.second_function_select);
	endtask

	task automatic report_and_stop();
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		drive_running = 1'b0;
		closed = 5'h00;
		failures = 0;
		comparisons = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_shutoff();
		t_logic();
		t_lock();
		t_speed();
		t_misc();
		report_and_stop();
	end

	// watchdog against a hung handshake
	initial begin
		#200_000;
		failures++;
		report_and_stop();
	end
endmodule

// ==== term_contacts.sv ====
// switch and relay contact model driving the five terminal pins
// assumes contact changes land off the clock edge, unrelated to it
`timescale 1ns/1ns
module term_contacts #(
	parameter int SETTLE_NS = 7
) (
	input wire logic [4:0] closed,
	output logic [4:0] terminal_in
);
	// pins follow the commanded contact state after a settle delay
	initial terminal_in = 5'h00;
	always @(closed) terminal_in <= #SETTLE_NS closed;
endmodule

// ==== term_router_pkg.sv ====
// constants, register map and carrier types for the input terminal router
// assumes a 50 MHz system clock and a single AHB-Lite master
package term_router_pkg;

	// clock and response timing
	localparam int CLK_HZ = 50_000_000;
	localparam int FAST_RESPONSE_MS = 2;
	localparam int SLOW_RESPONSE_MS = 20;
	localparam int SLOW_SAMPLE_MS = 10;
	localparam int SLOW_SAMPLE_CYCLES = CLK_HZ / 1000 * SLOW_SAMPLE_MS;
	localparam int SLOW_CNT_W = 20;
	localparam int NUM_TERM = 5;
	localparam int CODE_W = 14;

	// function-select codes
	localparam logic [CODE_W-1:0] CODE_LOW = 14'h0000;
	localparam logic [CODE_W-1:0] CODE_MID = 14'h0001;
	localparam logic [CODE_W-1:0] CODE_HIGH = 14'h0002;
	localparam logic [CODE_W-1:0] CODE_SECOND = 14'h0003;
	localparam logic [CODE_W-1:0] CODE_CUR_IN = 14'h0004;
	localparam logic [CODE_W-1:0] CODE_JOG = 14'h0005;
	localparam logic [CODE_W-1:0] CODE_THERMAL = 14'h0007;
	localparam logic [CODE_W-1:0] CODE_EXT_SPEED = 14'h0008;
	localparam logic [CODE_W-1:0] CODE_CONV_EN = 14'h000A;
	localparam logic [CODE_W-1:0] CODE_INTERLOCK = 14'h000C;
	localparam logic [CODE_W-1:0] CODE_PID = 14'h000E;
	localparam logic [CODE_W-1:0] CODE_PANEL_EXT = 14'h0010;
	localparam logic [CODE_W-1:0] CODE_VF = 14'h0012;
	localparam logic [CODE_W-1:0] CODE_SHUTOFF = 14'h0018;
	localparam logic [CODE_W-1:0] CODE_SELF_HOLD = 14'h0019;
	localparam logic [CODE_W-1:0] CODE_TRAVERSE = 14'h0025;
	localparam logic [CODE_W-1:0] CODE_FWD = 14'h003C;
	localparam logic [CODE_W-1:0] CODE_REV = 14'h003D;
	localparam logic [CODE_W-1:0] CODE_RESET = 14'h003E;
	localparam logic [CODE_W-1:0] CODE_PANEL_NET = 14'h0041;
	localparam logic [CODE_W-1:0] CODE_EXT_NET = 14'h0042;
	localparam logic [CODE_W-1:0] CODE_CMD_SRC = 14'h0043;
	localparam logic [CODE_W-1:0] CODE_NONE = 14'h270F;

	// terminal index allowed to carry forward / reverse run
	localparam int FWD_TERM = 0;
	localparam int REV_TERM = 1;

	// shutoff logic selection and operation mode values
	localparam logic [2:0] SHUTOFF_NO = 3'h0;
	localparam logic [2:0] SHUTOFF_NC = 3'h2;
	localparam logic [2:0] SHUTOFF_MIXED = 3'h4;
	localparam logic [3:0] OPMODE_INTERLOCK = 4'h7;

	// register byte offsets
	localparam logic [7:0] OFS_FUNC_SEL0 = 8'h00;
	localparam logic [7:0] OFS_FUNC_SEL4 = 8'h10;
	localparam logic [7:0] OFS_REMOTE_SEL = 8'h14;
	localparam logic [7:0] OFS_SHUTOFF_SEL = 8'h18;
	localparam logic [7:0] OFS_OPMODE = 8'h1C;
	localparam logic [7:0] OFS_EXT_ACCESS = 8'h20;
	localparam logic [7:0] OFS_COMM_CTRL = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_TERM_RAW = 8'h2C;

	// reset values of the per-terminal function selects
	localparam logic [CODE_W-1:0] RST_SEL0 = CODE_FWD;
	localparam logic [CODE_W-1:0] RST_SEL1 = CODE_REV;
	localparam logic [CODE_W-1:0] RST_SEL2 = CODE_LOW;
	localparam logic [CODE_W-1:0] RST_SEL3 = CODE_MID;
	localparam logic [CODE_W-1:0] RST_SEL4 = CODE_HIGH;

	// speed source encoding
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_PID = 2'h1;
	localparam logic [1:0] SRC_MULTI = 2'h2;
	localparam logic [1:0] SRC_JOG = 2'h3;

	// decoded commands to the drive control, also the status word
	typedef struct packed {
		logic [1:0] speed_source;
		logic command_source_switch;
		logic external_net_switch;
		logic panel_net_switch;
		logic drive_reset_input;
		logic reverse_run_cmd;
		logic forward_run_cmd;
		logic traverse_select;
		logic start_self_hold;
		logic decel_stop;
		logic coast_stop;
		logic start_allowed;
		logic output_cut;
		logic output_shutoff;
		logic vf_switchover;
		logic panel_external_switch;
		logic pid_valid;
		logic panel_op_interlock;
		logic converter_operation_enable;
		logic ext_thermal_relay;
		logic terminal2_voltage_valid;
		logic current_input_select;
		logic second_function_select;
		logic jog_select;
		logic remote_accel;
		logic remote_decel;
		logic remote_clear;
		logic extended_speed_select;
		logic speed_high_input;
		logic speed_mid_input;
		logic speed_low_input;
	} drive_cmd_t;

	// AHB-Lite slave outputs
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ahb_rsp_t;

endpackage

// ==== term_router_props.sv ====
// checker for the input terminal router: bus handshake and decoded command relations
// assumes it is bound to the router and sees only the router's ports
`timescale 1ns/1ns
module term_router_props
	import term_router_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic drive_running,
	input drive_cmd_t drive_cmd
);
	logic live_r;

	// the command word holds reset zeros until one edge after release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			live_r <= 1'b0;
		else
			live_r <= 1'b1;
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state is not exactly one cycle");
	resp_okay_a: assert property (!hresp)
		else $error("bus response is not okay");
	cut_follow_a: assert property (live_r |-> drive_cmd.output_cut == drive_cmd.output_shutoff)
		else $error("output cut differs from shutoff");
	start_block_a: assert property (live_r |-> drive_cmd.start_allowed != drive_cmd.output_shutoff)
		else $error("start allowed while shut off");
	coast_stop_a: assert property (drive_cmd.coast_stop |-> drive_cmd.output_shutoff && !drive_cmd.decel_stop)
		else $error("coast stop without shutoff or with decel stop");
	coast_run_a: assert property (live_r |-> drive_cmd.coast_stop == ($past(drive_running) && drive_cmd.output_shutoff))
		else $error("coast stop does not follow running and shutoff");
	decel_run_a: assert property (live_r |-> drive_cmd.decel_stop == ($past(drive_running)
		&& !drive_cmd.output_shutoff && !drive_cmd.forward_run_cmd && !drive_cmd.reverse_run_cmd))
		else $error("decel stop does not follow running and run commands");
	volt_invalid_a: assert property (drive_cmd.current_input_select |-> !drive_cmd.terminal2_voltage_valid)
		else $error("voltage input valid with current select");
	jog_first_a: assert property (drive_cmd.jog_select |-> drive_cmd.speed_source == SRC_JOG)
		else $error("jog does not win speed source");
	remote_mask_a: assert property (drive_cmd.remote_clear || drive_cmd.remote_decel || drive_cmd.remote_accel
		|-> !(drive_cmd.speed_low_input || drive_cmd.speed_mid_input || drive_cmd.speed_high_input))
		else $error("speed input active in remote mode");
endmodule

bind input_terminal_function_router term_router_props i_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .drive_running(drive_running), .drive_cmd(drive_cmd));
